// ---- rtl/gpeis_pkg.sv ----
// constants, types and register map of the gpio edge interrupt status block
// assumes a 16-bit apb byte address; every register is one aligned 32-bit word
package gpeis_pkg;

    // register indices; byte address is four times the index, as 1911h is not word aligned
    localparam logic [15:0] LOW_FLAGS_IDX = 16'h1910;
    localparam logic [15:0] UP_FLAGS_IDX = 16'h1911;
    localparam logic [15:0] LOW_MASK_IDX = 16'h1920;
    localparam logic [15:0] UP_MASK_IDX = 16'h1921;
    localparam logic [15:0] LOW_FLAGS_ADDR = {LOW_FLAGS_IDX[13:0], 2'h0};
    localparam logic [15:0] UP_FLAGS_ADDR = {UP_FLAGS_IDX[13:0], 2'h0};
    localparam logic [15:0] LOW_MASK_ADDR = {LOW_MASK_IDX[13:0], 2'h0};
    localparam logic [15:0] UP_MASK_ADDR = {UP_MASK_IDX[13:0], 2'h0};

    // field positions: pins 1..7 from bit 0, pins 21..32 from bit 4
    localparam int LOW_PINS = 7;
    localparam int UP_PINS = 12;
    localparam int LOW_LSB = 0;
    localparam int UP_LSB = 4;
    localparam int ALL_PINS = LOW_PINS + UP_PINS;
    localparam logic [15:0] LOW_VALID = 16'h007f;
    localparam logic [15:0] UP_VALID = 16'hfff0;

    // reset values
    localparam logic [15:0] FLAGS_RST = 16'h0000;
    localparam logic [15:0] MASK_RST = 16'h0000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // monitored pin levels
    typedef struct packed {
        logic [UP_PINS-1:0] up;
        logic [LOW_PINS-1:0] low;
    } gpeis_pins_type;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [15:0] paddr;
        logic [31:0] pwdata;
    } gpeis_apb_req_type;

    // whole state of the block
    typedef struct packed {
        gpeis_pins_type sync1;
        gpeis_pins_type sync2;
        gpeis_pins_type prev;
        logic [15:0] lowFlags;
        logic [15:0] upFlags;
        logic [15:0] lowMask;
        logic [15:0] upMask;
        logic [31:0] rdata;
    } gpeis_state_type;

    localparam gpeis_state_type STATE_RST = '{
        sync1: '0, sync2: '0, prev: '0,
        lowFlags: FLAGS_RST, upFlags: FLAGS_RST,
        lowMask: MASK_RST, upMask: MASK_RST,
        rdata: RDATA_RST
    };

endpackage

// ---- rtl/gpeis_top.sv ----
// both-edge gpio interrupt status flags with mask and apb access
// assumes pins are asynchronous to sys_clk; apb master on sys_clk (10 MHz)
//
// What this block does
// [R1] any rising or falling edge on a monitored pin sets its flag
// [R2] flag holds until software writes one to its bit; zero leaves it
// [R3] pins 1 to 7 sit at bits 0 to 6 of lower word
// [R4] pin 4 reported at bit 3 of lower word, same behaviour
// [R5] word at index 1911h holds pins 21-32 in bits 4-15; reset zero
// [R6] repeated edges keep flag set; edge beats a same-cycle clearing write
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module gpeis_top (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // monitored pins
    input wire gpeis_pkg::gpeis_pins_type pins,
    // apb slave
    input wire gpeis_pkg::gpeis_apb_req_type apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt
    output logic irq
);

    gpeis_pkg::gpeis_state_type state_q;
    gpeis_pkg::gpeis_state_type state_d;
    logic [gpeis_pkg::ALL_PINS-1:0] edges;
    logic [15:0] lowSet;
    logic [15:0] upSet;
    logic accessPhase;
    logic setupPhase;
    logic hitLowFlags;
    logic hitUpFlags;
    logic hitLowMask;
    logic hitUpMask;
    logic addrHit;
    logic wrLow;
    logic wrUp;
    logic [15:0] wdata;

    // either direction counts, so xor of synced level against its previous one
    assign edges = state_q.sync2 ^ state_q.prev; // see [R1]
    assign lowSet = 16'(edges[gpeis_pkg::LOW_PINS-1:0]) << gpeis_pkg::LOW_LSB; // see [R3]
    assign upSet = 16'(edges[gpeis_pkg::ALL_PINS-1:gpeis_pkg::LOW_PINS]) << gpeis_pkg::UP_LSB; // see [R5]

    assign setupPhase = apbReq.psel && !apbReq.penable;
    assign accessPhase = apbReq.psel && apbReq.penable;
    assign hitLowFlags = apbReq.paddr == gpeis_pkg::LOW_FLAGS_ADDR;
    assign hitUpFlags = apbReq.paddr == gpeis_pkg::UP_FLAGS_ADDR;
    assign hitLowMask = apbReq.paddr == gpeis_pkg::LOW_MASK_ADDR;
    assign hitUpMask = apbReq.paddr == gpeis_pkg::UP_MASK_ADDR;
    assign addrHit = hitLowFlags || hitUpFlags || hitLowMask || hitUpMask;
    assign wrLow = accessPhase && apbReq.pwrite && hitLowFlags;
    assign wrUp = accessPhase && apbReq.pwrite && hitUpFlags;
    assign wdata = apbReq.pwdata[15:0];

    always_comb
    begin
        state_d = state_q;
        // two flops of synchroniser, third holds the last level for edge compare
        state_d.sync1 = pins;
        state_d.sync2 = state_q.sync1;
        state_d.prev = state_q.sync2;
        // clear first, then set, so an edge in the clearing cycle survives
        state_d.lowFlags = ((state_q.lowFlags & ~(wrLow ? wdata : 16'h0000)) | lowSet)
            & gpeis_pkg::LOW_VALID; // see [R2] see [R4] see [R6]
        state_d.upFlags = ((state_q.upFlags & ~(wrUp ? wdata : 16'h0000)) | upSet)
            & gpeis_pkg::UP_VALID; // see [R2] see [R5] see [R6]
        if (accessPhase && apbReq.pwrite && hitLowMask)
        begin
            state_d.lowMask = wdata & gpeis_pkg::LOW_VALID;
        end
        if (accessPhase && apbReq.pwrite && hitUpMask)
        begin
            state_d.upMask = wdata & gpeis_pkg::UP_VALID;
        end
        // read data captured in setup so prdata comes from a flop in access
        if (setupPhase)
        begin
            case (1'b1)
                hitLowFlags: state_d.rdata = {16'h0000, state_q.lowFlags};
                hitUpFlags: state_d.rdata = {16'h0000, state_q.upFlags};
                hitLowMask: state_d.rdata = {16'h0000, state_q.lowMask};
                hitUpMask: state_d.rdata = {16'h0000, state_q.upMask};
                default: state_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= gpeis_pkg::STATE_RST;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // no wait states: every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = accessPhase && !addrHit;
    assign prdata = state_q.rdata;
    assign irq = |((state_q.lowFlags & state_q.lowMask) | (state_q.upFlags & state_q.upMask));

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_any_edge_sets: assert property ( // see [R1]
        (lowSet != 16'h0000) |=> ((state_q.lowFlags & $past(lowSet)) == $past(lowSet)))
        else $error("edge on lower pin did not set its flag");

    a_pin4_rise_fall: assert property ( // see [R4]
        (state_q.sync2.low[3] != state_q.prev.low[3]) |=> state_q.lowFlags[3])
        else $error("pin 4 edge not reported at bit 3");

    a_clear_on_one: assert property ( // see [R2]
        (wrLow && wdata[0] && !lowSet[0]) |=> !state_q.lowFlags[0])
        else $error("writing one did not clear lower flag");

    a_zero_keeps: assert property ( // see [R2]
        (wrLow && wdata == 16'h0000) |=> ((state_q.lowFlags & $past(state_q.lowFlags))
        == $past(state_q.lowFlags)))
        else $error("writing zero disturbed a flag");

    a_flag_sticky: assert property ( // see [R6]
        (!wrUp && state_q.upFlags != 16'h0000)
        |=> ((state_q.upFlags & $past(state_q.upFlags)) == $past(state_q.upFlags)))
        else $error("upper flag dropped without a clearing write");

    a_set_beats_clear: assert property ( // see [R6]
        (wrLow || wrUp)
        |=> (((state_q.lowFlags & $past(lowSet)) == $past(lowSet))
        && ((state_q.upFlags & $past(upSet)) == $past(upSet))))
        else $error("edge lost in clearing cycle");

    a_upper_layout: assert property ( // see [R5]
        (state_q.sync2.up[0] != state_q.prev.up[0]) |=> state_q.upFlags[4])
        else $error("pin 21 edge not reported at bit 4");

    a_unused_zero: assert property ( // see [R3] see [R5]
        ((state_q.lowFlags & ~gpeis_pkg::LOW_VALID) == 16'h0000)
        && ((state_q.upFlags & ~gpeis_pkg::UP_VALID) == 16'h0000))
        else $error("flag set outside its field");

    a_pin_latency: assert property ( // see [R1]
        $changed(state_q.sync1.low[6]) ##1 !wrLow |=> state_q.lowFlags[6])
        else $error("pin 7 change not flagged two cycles later");

    a_upper_edge_sets: assert property ( // see [R1]
        (upSet != 16'h0000)
        |=> ((state_q.upFlags & $past(upSet)) == $past(upSet)))
        else $error("edge on upper pin did not set its flag");

    // a flag may only appear where an edge was seen, never out of nothing
    a_low_no_stray: assert property ( // see [R1]
        (lowSet == 16'h0000)
        |=> ((state_q.lowFlags & ~$past(state_q.lowFlags)) == 16'h0000))
        else $error("lower flag set without an edge");

    a_up_no_stray: assert property ( // see [R1]
        (upSet == 16'h0000)
        |=> ((state_q.upFlags & ~$past(state_q.upFlags)) == 16'h0000))
        else $error("upper flag set without an edge");

    a_clear_upper: assert property ( // see [R2]
        (wrUp && wdata[15] && !upSet[15])
        |=> !state_q.upFlags[15])
        else $error("writing one did not clear upper flag");

    a_zero_keeps_up: assert property ( // see [R2]
        (wrUp && wdata == 16'h0000)
        |=> ((state_q.upFlags & $past(state_q.upFlags)) == $past(state_q.upFlags)))
        else $error("writing zero disturbed an upper flag");

    a_low_sticky: assert property ( // see [R6]
        (!wrLow && state_q.lowFlags != 16'h0000)
        |=> ((state_q.lowFlags & $past(state_q.lowFlags)) == $past(state_q.lowFlags)))
        else $error("lower flag dropped without a clearing write");

    a_pin1_bit0: assert property ( // see [R3]
        (state_q.sync2.low[0] != state_q.prev.low[0])
        |=> state_q.lowFlags[0])
        else $error("pin 1 edge not reported at bit 0");

    a_pin7_bit6: assert property ( // see [R3]
        (state_q.sync2.low[6] != state_q.prev.low[6])
        |=> state_q.lowFlags[6])
        else $error("pin 7 edge not reported at bit 6");

    a_pin22_bit5: assert property ( // see [R5]
        (state_q.sync2.up[1] != state_q.prev.up[1])
        |=> state_q.upFlags[5])
        else $error("pin 22 edge not reported at bit 5");

    a_pin32_bit15: assert property ( // see [R5]
        (state_q.sync2.up[11] != state_q.prev.up[11])
        |=> state_q.upFlags[15])
        else $error("pin 32 edge not reported at bit 15");

    // set wins, so no clearing write can hide the flag two cycles on
    a_up_latency: assert property ( // see [R1]
        $changed(state_q.sync1.up[11])
        |-> ##2 state_q.upFlags[15])
        else $error("pin 32 change not flagged two cycles later");

    a_read_lower: assert property ( // see [R3]
        (setupPhase && hitLowFlags)
        |=> (prdata == {16'h0000, $past(state_q.lowFlags)}))
        else $error("lower flag word not returned on read");

    a_read_upper: assert property ( // see [R5]
        (setupPhase && hitUpFlags)
        |=> (prdata == {16'h0000, $past(state_q.upFlags)}))
        else $error("upper flag word not returned on read");

    c_pin_flag: cover property (lowSet != 16'h0000 ##1 irq);
    c_clear_flag: cover property (wrLow && wdata != 16'h0000 && lowSet == 16'h0000);
    c_set_and_clear: cover property (wrLow && (lowSet & wdata) != 16'h0000);
    c_bad_addr: cover property (pslverr);
    c_up_flag: cover property (upSet[15] ##1 irq);

endmodule // gpeis_top

// ---- bench/tb.sv ----
// self-checking bench for the gpio edge interrupt status block
// assumes an apb slave that answers in its own time and a two-flop pin synchroniser
`timescale 1ns/1ps
module tb;
    typedef struct packed {logic [18:0] pinv; logic [15:0] addr; logic [31:0] exp;} gpeis_row_type;
    localparam logic [15:0] loF = gpeis_pkg::LOW_FLAGS_ADDR;
    localparam logic [15:0] upF = gpeis_pkg::UP_FLAGS_ADDR;
    logic sys_clk;
    logic rst;
    gpeis_pkg::gpeis_pins_type pins;
    gpeis_pkg::gpeis_apb_req_type apbReq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    int nErrors;
    int cmpCount;
    logic [31:0] rdata;
    logic slvErr;
    logic [15:0] oth;
    gpeis_row_type rows [7];

    gpeis_top gpeis_top_inst (.sys_clk(sys_clk), .rst(rst), .pins(pins), .apbReq(apbReq), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq));

    task automatic give_verdict();
        if (nErrors == 0 && cmpCount > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp)
        begin
            nErrors++;
            $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask

    // request held until pready is seen high; the watchdog bounds the wait
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge sys_clk);
        apbReq.penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rdata = prdata;
        slvErr = pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdata, e);
    endtask

    // four edges cover the synchroniser and the flag register
    task automatic pulse(input logic [18:0] v);
        @(posedge sys_clk);
        pins <= v;
        repeat (4) @(posedge sys_clk);
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    initial
    begin
        repeat (5000) @(posedge sys_clk);
        nErrors++;
        give_verdict();
    end

    initial
    begin
        rst = 1'b1;
        pins = '0;
        apbReq = '0;
        nErrors = 0;
        cmpCount = 0;
        rows = '{
            '{19'h00001, loF, 32'h0001},
            '{19'h00008, loF, 32'h0008},
            '{19'h00040, loF, 32'h0040},
            '{19'h0007f, loF, 32'h007f},
            '{19'h00080, upF, 32'h0010},
            '{19'h40000, upF, 32'h8000},
            '{19'h7ff80, upF, 32'hfff0}};
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        rd(loF, 32'h0);
        rd(upF, 32'h0);
        chk({31'h0, irq}, 32'h0);
        foreach (rows[i])
        begin
            oth = (rows[i].addr == loF) ? upF : loF;
            pulse(rows[i].pinv);
            rd(rows[i].addr, rows[i].exp);
            rd(oth, 32'h0);
            apb(1'b1, rows[i].addr, 32'h0);
            rd(rows[i].addr, rows[i].exp);
            apb(1'b1, rows[i].addr, rows[i].exp);
            rd(rows[i].addr, 32'h0);
            pulse('0);
            rd(rows[i].addr, rows[i].exp);
            pulse(rows[i].pinv);
            pulse('0);
            rd(rows[i].addr, rows[i].exp);
            apb(1'b1, rows[i].addr, 32'h0000_ffff);
        end
        // pin edge lands on the very edge of the clearing write
        pulse(19'h00001);
        @(posedge sys_clk);
        pins <= '0;
        apb(1'b1, loF, 32'h1);
        rd(loF, 32'h1);
        apb(1'b1, loF, 32'h1);
        apb(1'b1, gpeis_pkg::LOW_MASK_ADDR, 32'h8);
        rd(gpeis_pkg::LOW_MASK_ADDR, 32'h8);
        chk({30'h0, pready, slvErr}, 32'h2);
        pulse(19'h00001);
        chk({31'h0, irq}, 32'h0);
        pulse(19'h00009);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, loF, 32'h8);
        rd(loF, 32'h1);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, gpeis_pkg::UP_MASK_ADDR, 32'hffff_ffff);
        rd(gpeis_pkg::UP_MASK_ADDR, 32'hfff0);
        pulse(19'h40009);
        chk({31'h0, irq}, 32'h1);
        rd(16'h0000, 32'h0);
        chk({31'h0, slvErr}, 32'h1);
        // mid-run reset with the pins low, so no edge appears at release
        @(posedge sys_clk);
        rst <= 1'b1;
        pins <= '0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd(loF, 32'h0);
        rd(upF, 32'h0);
        chk({31'h0, irq}, 32'h0);
        give_verdict();
    end
endmodule // tb
